// ===== hw/ocp_pkg.sv
// Purpose: constants and types for the output compare / pwm unit
// Assumes: ahb-lite register access, 32-bit data, one word per register
// Notes:   offsets and bit positions are shared with the bench
package ocp_pkg;
   // register byte offsets
   localparam logic [7:0] OFF_CTRL1  = 8'h00;
   localparam logic [7:0] OFF_CTRL2  = 8'h04;
   localparam logic [7:0] OFF_PRIM   = 8'h08;
   localparam logic [7:0] OFF_SEC    = 8'h0C;
   localparam logic [7:0] OFF_STATUS = 8'h10;
   localparam logic [7:0] OFF_MASK   = 8'h14;
   localparam logic [7:0] OFF_COUNT  = 8'h18;
   // control one fields
   localparam int CTRL1_IDLE_BIT  = 13;
   localparam int CTRL1_CSEL_LSB  = 10;
   localparam int CTRL1_FEN_LSB   = 7;
   localparam int CTRL1_FST_LSB   = 4;
   localparam int CTRL1_TMODE_BIT = 3;
   localparam int CTRL1_MODE_LSB  = 0;
   // control two fields
   localparam int CTRL2_CASC_BIT  = 8;
   localparam int CTRL2_TRIG_BIT  = 7;
   localparam int CTRL2_TRIS_BIT  = 5;
   localparam int CTRL2_SYNC_LSB  = 0;
   localparam logic [4:0] SYNC_SELF = 5'h1F;
   // reset values
   localparam logic [15:0] CTRL1_RST = 16'h0000;
   localparam logic [15:0] CTRL2_RST = 16'h0020;
   // status bits
   localparam int ST_MATCH = 0;
   localparam int ST_FAULT = 1;
   localparam int ST_WIDTH = 2;
   // clock select codes
   localparam logic [2:0] CSEL_PCLK = 3'h7;
   localparam logic [2:0] CSEL_T1   = 3'h4;
   localparam logic [2:0] CSEL_T5   = 3'h3;
   localparam logic [2:0] CSEL_T4   = 3'h2;
   localparam logic [2:0] CSEL_T3   = 3'h1;
   localparam logic [2:0] CSEL_T2   = 3'h0;
   // compare modes
   typedef enum logic [2:0] {
      OCP_OFF    = 3'h0, OCP_HIGH  = 3'h1, OCP_LOW   = 3'h2, OCP_TOGGLE = 3'h3,
      OCP_SINGLE = 3'h4, OCP_CONT  = 3'h5, OCP_EDGE  = 3'h6, OCP_CENTER = 3'h7
   } ocp_mode_t;
   // ahb address phase capture
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
   } ocp_aphase_t;
endpackage

// ===== hw/ocp_unit.sv
// Purpose: output compare channel with single-edge, pulse and pwm modes
// Assumes: one clock hclk, prescaler ticks arrive as async pins
// Notes:   pwm values are double buffered and reloaded at period end
//
// Overview of operation
// - a cleared tristate bit makes the channel drive its output pin
// - output rests at default level, flips when count equals primary value
// - double-compare modes return output to default on secondary match
// - flag on primary match in single modes, secondary match in double modes
// - single-shot pulse once, rearmed by control one write; continuous repeats
// - edge and center pwm, values held in hidden double buffers
// - pwm duty from primary compare, period from secondary compare
// - source field 0x1F with trigger select clear means self sync
// - clock select: 111 pclk, 100..000 timers 1,5,4,3,2, others reserved
// - timer source clocks the channel through its prescaler tick
// - three fault enable bits gate comparator, second and first fault pins
// - mode field in control one bits 2:0 selects operation
`timescale 1ns/1ns
module ocp_unit #(
   parameter int CW = 16
) (
   // clock and reset
   input  wire logic          hclk,
   input  wire logic          hresetn,
   // ahb-lite slave
   input  wire logic          hsel,
   input  wire logic [31:0]   haddr,
   input  wire logic [1:0]    htrans,
   input  wire logic          hwrite,
   input  wire logic [2:0]    hsize,
   input  wire logic [31:0]   hwdata,
   input  wire logic          hready,
   output logic      [31:0]   hrdata,
   output logic               hreadyout,
   output logic               hresp,
   // timing sources and faults (async pins)
   input  wire logic [4:0]    prescale_tick,
   input  wire logic [4:0]    sync_in,
   input  wire logic [2:0]    fault_in,
   input  wire logic          cpu_idle,
   // channel pin and interrupt
   output logic               odd_channel_output_o,
   output logic               odd_channel_output_oe,
   output logic               irq
);
   ////////////////////////////////////////////////////////////////////
   // pin synchronisers, one generate loop over all async inputs
   localparam int NS = 14;
   logic [NS-1:0] pin_raw;
   logic [NS-1:0] meta_q;
   logic [NS-1:0] sync_q;
   assign pin_raw = {cpu_idle, fault_in, sync_in, prescale_tick};
   genvar gi;
   generate
      for (gi = 0; gi < NS; gi++) begin : g_sync
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               meta_q[gi] <= 1'b0;
               sync_q[gi] <= 1'b0;
            end else begin
               meta_q[gi] <= pin_raw[gi];
               sync_q[gi] <= meta_q[gi];
            end
         end
      end
   endgenerate
   logic [4:0] tick_s;
   logic [4:0] syncin_s;
   logic [2:0] fault_s;
   logic       idle_s;
   logic [4:0] tick_prev_q;
   logic [4:0] sync_prev_q;
   assign tick_s   = sync_q[4:0];
   assign syncin_s = sync_q[9:5];
   assign fault_s  = sync_q[12:10];
   assign idle_s   = sync_q[13];

   ////////////////////////////////////////////////////////////////////
   // ahb-lite slave: zero wait states, always okay
   ocp_pkg::ocp_aphase_t ap_q;
   logic        take;
   logic [15:0] ctrl1_q;
   logic [15:0] ctrl2_q;
   logic [CW-1:0] prim_q;
   logic [CW-1:0] sec_q;
   logic [ocp_pkg::ST_WIDTH-1:0] status_q;
   logic [ocp_pkg::ST_WIDTH-1:0] mask_q;
   logic [CW-1:0] count_q;
   assign take      = hsel && hready && htrans[1];
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_q <= '0;
      end else begin
         ap_q.wr   <= take && hwrite;
         ap_q.rd   <= take && !hwrite;
         ap_q.addr <= haddr[7:0];
      end
   end
   logic wr_c1;
   logic wr_c2;
   logic wr_pr;
   logic wr_se;
   logic wr_st;
   logic wr_mk;
   assign wr_c1 = ap_q.wr && (ap_q.addr == ocp_pkg::OFF_CTRL1);
   assign wr_c2 = ap_q.wr && (ap_q.addr == ocp_pkg::OFF_CTRL2);
   assign wr_pr = ap_q.wr && (ap_q.addr == ocp_pkg::OFF_PRIM);
   assign wr_se = ap_q.wr && (ap_q.addr == ocp_pkg::OFF_SEC);
   assign wr_st = ap_q.wr && (ap_q.addr == ocp_pkg::OFF_STATUS);
   assign wr_mk = ap_q.wr && (ap_q.addr == ocp_pkg::OFF_MASK);
   logic [31:0] rd_mux;
   assign rd_mux = (ap_q.addr == ocp_pkg::OFF_CTRL1)  ? {16'h0000, ctrl1_q} :
                   (ap_q.addr == ocp_pkg::OFF_CTRL2)  ? {16'h0000, ctrl2_q} :
                   (ap_q.addr == ocp_pkg::OFF_PRIM)   ? 32'(prim_q) :
                   (ap_q.addr == ocp_pkg::OFF_SEC)    ? 32'(sec_q) :
                   (ap_q.addr == ocp_pkg::OFF_STATUS) ? 32'(status_q) :
                   (ap_q.addr == ocp_pkg::OFF_MASK)   ? 32'(mask_q) :
                   (ap_q.addr == ocp_pkg::OFF_COUNT)  ? 32'(count_q) : 32'h00000000;
   assign hrdata = ap_q.rd ? rd_mux : 32'h00000000;

   ////////////////////////////////////////////////////////////////////
   // control fields
   ocp_pkg::ocp_mode_t mode;
   logic [2:0] csel;
   logic [2:0] fen;
   logic [4:0] ssel;
   logic       trig_sel;
   logic       tris;
   assign mode     = ocp_pkg::ocp_mode_t'(ctrl1_q[ocp_pkg::CTRL1_MODE_LSB +: 3]);
   assign csel     = ctrl1_q[ocp_pkg::CTRL1_CSEL_LSB +: 3];
   assign fen      = ctrl1_q[ocp_pkg::CTRL1_FEN_LSB +: 3];
   assign ssel     = ctrl2_q[ocp_pkg::CTRL2_SYNC_LSB +: 5];
   assign trig_sel = ctrl2_q[ocp_pkg::CTRL2_TRIG_BIT];
   assign tris     = ctrl2_q[ocp_pkg::CTRL2_TRIS_BIT];

   // clock enable from selected source; reserved codes never tick
   logic [4:0] tick_rise;
   logic       tick;
   assign tick_rise = tick_s & ~tick_prev_q;
   assign tick = (csel == ocp_pkg::CSEL_PCLK) ? 1'b1 :
                 (csel == ocp_pkg::CSEL_T1)   ? tick_rise[0] :
                 (csel == ocp_pkg::CSEL_T5)   ? tick_rise[4] :
                 (csel == ocp_pkg::CSEL_T4)   ? tick_rise[3] :
                 (csel == ocp_pkg::CSEL_T3)   ? tick_rise[2] :
                 (csel == ocp_pkg::CSEL_T2)   ? tick_rise[1] : 1'b0;
   logic halt;
   assign halt = ctrl1_q[ocp_pkg::CTRL1_IDLE_BIT] && idle_s;

   // faults: any enabled active input latches its status bit
   logic [2:0] fault_hit;
   logic       faulted;
   assign fault_hit = fen & fault_s;
   assign faulted   = |ctrl1_q[ocp_pkg::CTRL1_FST_LSB +: 3];

   // external sync source rising edge, or self sync at period end
   logic self_sync;
   logic ext_sync;
   assign self_sync = (ssel == ocp_pkg::SYNC_SELF) && !trig_sel;
   assign ext_sync  = !self_sync && (ssel < 5'h05) &&
                      syncin_s[ssel[2:0]] && !sync_prev_q[ssel[2:0]];

   ////////////////////////////////////////////////////////////////////
   // compare engine
   logic [CW-1:0] duty_buf_q;
   logic [CW-1:0] per_buf_q;
   logic          up_q;
   logic          out_q;
   logic          done_q;
   logic          is_pwm;
   logic          is_dbl;
   logic          run;
   logic          prim_hit;
   logic          sec_hit;
   logic          wrap;
   logic          duty_end;
   logic [CW-1:0] cmp_p;
   logic [CW-1:0] cmp_s;
   assign is_pwm   = (mode == ocp_pkg::OCP_EDGE) || (mode == ocp_pkg::OCP_CENTER);
   assign is_dbl   = (mode == ocp_pkg::OCP_SINGLE) || (mode == ocp_pkg::OCP_CONT);
   assign run      = (mode != ocp_pkg::OCP_OFF) && tick && !halt;
   assign cmp_p    = is_pwm ? duty_buf_q : prim_q;
   assign cmp_s    = is_pwm ? per_buf_q : sec_q;
   assign prim_hit = run && (count_q == cmp_p);
   assign sec_hit  = run && (count_q == cmp_s);
   assign wrap     = (mode == ocp_pkg::OCP_CENTER) ? (run && !up_q && count_q == '0) :
                     ((self_sync && sec_hit) || (run && ext_sync));
   // fall one tick early so the pin stays high for exactly duty ticks
   assign duty_end = run && ((count_q + CW'(1)) == duty_buf_q);

   // timer: up count with reload, center mode counts up then down
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count_q <= '0;
         up_q    <= 1'b1;
      end else if (mode == ocp_pkg::OCP_OFF) begin
         count_q <= '0;
         up_q    <= 1'b1;
      end else if (mode == ocp_pkg::OCP_CENTER && run) begin
         if (up_q && sec_hit) begin
            up_q    <= 1'b0;
            count_q <= count_q - 1'b1;
         end else if (!up_q && count_q == '0) begin
            up_q    <= 1'b1;
            count_q <= count_q + 1'b1;
         end else begin
            count_q <= up_q ? count_q + 1'b1 : count_q - 1'b1;
         end
      end else if (wrap) begin
         count_q <= '0;
      end else if (run) begin
         count_q <= count_q + 1'b1;
      end
   end

   // pwm shadow buffers, loaded at period boundary or whenever the mode is not pwm
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         duty_buf_q <= '0;
         per_buf_q  <= '0;
      end else if (!is_pwm || wrap) begin
         duty_buf_q <= prim_q;
         per_buf_q  <= sec_q;
      end
   end

   // output level: default low; in double modes rises on primary, falls on secondary
   logic out_d;
   logic flag_ev;
   always_comb begin
      out_d   = out_q;
      flag_ev = 1'b0;
      case (mode)
         ocp_pkg::OCP_OFF: out_d = 1'b0;
         ocp_pkg::OCP_HIGH: begin
            if (prim_hit) out_d = 1'b1;
            flag_ev = prim_hit;
         end
         ocp_pkg::OCP_LOW: begin
            if (prim_hit) out_d = 1'b0;
            flag_ev = prim_hit;
         end
         ocp_pkg::OCP_TOGGLE: begin
            if (prim_hit) out_d = !out_q;
            flag_ev = prim_hit;
         end
         ocp_pkg::OCP_SINGLE, ocp_pkg::OCP_CONT: begin
            if (!done_q && prim_hit) out_d = 1'b1;
            if (!done_q && sec_hit) out_d = 1'b0;
            flag_ev = !done_q && sec_hit;
         end
         ocp_pkg::OCP_EDGE: begin
            if (wrap) out_d = (duty_buf_q != '0);
            else if (duty_end) out_d = 1'b0;
            flag_ev = wrap;
         end
         ocp_pkg::OCP_CENTER: begin
            if (prim_hit) out_d = up_q;
            flag_ev = wrap;
         end
         default: out_d = 1'b0;
      endcase
      if (faulted) out_d = 1'b0;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         out_q       <= 1'b0;
         done_q      <= 1'b0;
         tick_prev_q <= '0;
         sync_prev_q <= '0;
      end else begin
         out_q       <= out_d;
         tick_prev_q <= tick_s;
         sync_prev_q <= syncin_s;
         if (wr_c1) done_q <= 1'b0;
         else if (mode == ocp_pkg::OCP_SINGLE && sec_hit && !done_q) done_q <= 1'b1;
      end
   end
   assign odd_channel_output_o  = out_q;
   assign odd_channel_output_oe = !tris;

   ////////////////////////////////////////////////////////////////////
   // registers; hardware-set fault status beats software clear
   logic [ocp_pkg::ST_WIDTH-1:0] st_set;
   assign st_set = {(|fault_hit), flag_ev};
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl1_q  <= ocp_pkg::CTRL1_RST;
         ctrl2_q  <= ocp_pkg::CTRL2_RST;
         prim_q   <= '0;
         sec_q    <= '0;
         status_q <= '0;
         mask_q   <= '0;
      end else begin
         if (wr_c1) ctrl1_q <= hwdata[15:0] & 16'h3FFF;
         ctrl1_q[ocp_pkg::CTRL1_FST_LSB +: 3] <=
            (wr_c1 ? hwdata[ocp_pkg::CTRL1_FST_LSB +: 3]
                   : ctrl1_q[ocp_pkg::CTRL1_FST_LSB +: 3]) | fault_hit;
         if (wr_c2) ctrl2_q <= hwdata[15:0] & 16'h01BF;
         if (wr_pr) prim_q <= hwdata[CW-1:0];
         if (wr_se) sec_q <= hwdata[CW-1:0];
         if (wr_mk) mask_q <= hwdata[ocp_pkg::ST_WIDTH-1:0];
         status_q <= (status_q & ~(wr_st ? hwdata[ocp_pkg::ST_WIDTH-1:0] : '0)) | st_set;
      end
   end
   assign irq = |(status_q & mask_q);

   ////////////////////////////////////////////////////////////////////
   // checks
   a_out_rise_prim: assert property (@(posedge hclk) disable iff (!hresetn)
      (mode == ocp_pkg::OCP_HIGH && prim_hit && !faulted) |=> out_q)
      else $error("output did not rise on primary match");
   a_out_fall_sec: assert property (@(posedge hclk) disable iff (!hresetn)
      (is_dbl && !done_q && sec_hit && !prim_hit) |=> !out_q)
      else $error("output did not return on secondary match");
   a_flag_set: assert property (@(posedge hclk) disable iff (!hresetn)
      flag_ev |=> status_q[ocp_pkg::ST_MATCH])
      else $error("match flag not set");
   a_single_once: assert property (@(posedge hclk) disable iff (!hresetn)
      (mode == ocp_pkg::OCP_SINGLE && done_q && !wr_c1) |=> done_q)
      else $error("single shot rearmed without write");
   a_fault_safe: assert property (@(posedge hclk) disable iff (!hresetn)
      (|fault_hit) |=> (faulted ##1 !out_q))
      else $error("fault did not force safe output");
   a_tris_drive: assert property (@(posedge hclk) disable iff (!hresetn)
      $fell(tris) |-> odd_channel_output_oe)
      else $error("output not driven with tristate cleared");
   a_idle_hold: assert property (@(posedge hclk) disable iff (!hresetn)
      (halt && mode != ocp_pkg::OCP_OFF) |=> $stable(count_q))
      else $error("counter moved in idle halt");
   a_reserved_clk: assert property (@(posedge hclk) disable iff (!hresetn)
      (csel == 3'h5 || csel == 3'h6) |-> !tick)
      else $error("reserved clock select ticked");
   a_pwm_buffer: assert property (@(posedge hclk) disable iff (!hresetn)
      (is_pwm && !wrap && wr_pr) |=> $stable(duty_buf_q))
      else $error("pwm buffer changed mid period");
endmodule

// ===== dv/ocp_far.sv
// Purpose: far side of the compare channel: pin load, fault sources, timer prescalers
// Assumes: the pin has a pull-down on the board, prescalers free-run from hclk
// Notes:   counts rising edges and high cycles of the pin for the bench
`timescale 1ns/1ns
module ocp_far (
   // clock and reset
   input  wire logic       hclk,
   input  wire logic       hresetn,
   // channel pin
   input  wire logic       pin_o,
   input  wire logic       pin_oe,
   // bench requests
   input  wire logic [2:0] fault_req,
   // towards the device
   output logic      [2:0] fault_in,
   output logic      [4:0] prescale_tick,
   // observations
   output logic            pin_level,
   output int              rises,
   output int              highs
);
   logic [5:0] div_q;
   logic       last_q;
   ////////////////////////////////////////////////////////////////////////////////
   // a released pin falls to the pull-down, never keeps the last driven value
   assign pin_level     = pin_oe ? pin_o : 1'b0;
   // timer k ticks every 4<<k cycles; slow enough for the 2-flop sync to see each edge
   assign prescale_tick = div_q[5:1];
   assign fault_in      = fault_req;
   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_q  <= 6'h00;
         last_q <= 1'b0;
         rises  <= 0;
         highs  <= 0;
      end else begin
         div_q  <= div_q + 6'h01;
         last_q <= pin_level;
         if (pin_level && !last_q) begin
            rises <= rises + 1;
         end
         if (pin_level) begin
            highs <= highs + 1;
         end
      end
   end
endmodule

// ===== dv/ocp_unit_tb.sv
// Purpose: self-checking bench for the compare channel over ahb-lite
// Assumes: zero-wait slave, pin counters in the far-side model
// Notes:   windows are whole pwm periods so high-cycle sums are exact
`timescale 1ns/1ns
module ocp_unit_tb;
   localparam int W = 256;
   logic        hclk, hresetn, hsel, hwrite, cpu_idle;
   logic [31:0] haddr, hwdata, hrdata, seed;
   logic [1:0]  htrans;
   logic [2:0]  hsize, fault_req, fault_in;
   logic [4:0]  sync_in, prescale_tick;
   logic        hreadyout, hresp, pin_o, pin_oe, irq, pin_level;
   wire         hready = hreadyout;
   int          rises, highs, fail_count, comparisons;
   ////////////////////////////////////////////////////////////////////////////////
   ocp_unit #(.CW(16)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .prescale_tick(prescale_tick),
      .sync_in(sync_in), .fault_in(fault_in), .cpu_idle(cpu_idle),
      .odd_channel_output_o(pin_o), .odd_channel_output_oe(pin_oe), .irq(irq));
   ocp_far far (.hclk(hclk), .hresetn(hresetn), .pin_o(pin_o), .pin_oe(pin_oe),
      .fault_req(fault_req), .fault_in(fault_in), .prescale_tick(prescale_tick),
      .pin_level(pin_level), .rises(rises), .highs(highs));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic tick(input int n);
      repeat (n) @(posedge hclk);
   endtask
   // entered at a rising edge; leaves at the edge where the data phase ended
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      hsel <= 1'b1; haddr <= {24'h000000, a}; htrans <= 2'h2; hwrite <= w;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] unused;
      bus(1'b1, a, d, unused);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      bus(1'b0, a, 32'h00000000, d);
   endtask
   task automatic check_val(input string what, input logic [31:0] e, input logic [31:0] s);
      comparisons++;
      if (s !== e) begin
         fail_count++;
         $display("mismatch %s expected %0h seen %0h", what, e, s);
      end
   endtask
   task automatic check_range(input string what, input int lo, input int hi,
                              input logic [31:0] s);
      comparisons++;
      if ($isunknown(s) || s < lo || s > hi) begin
         fail_count++;
         $display("mismatch %s expected %0d..%0d seen %0d", what, lo, hi, s);
      end
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end
   initial begin
      tick(20000);
      fail_count++;
      $display("mismatch watchdog expected finish seen timeout");
      conclude();
   end
   initial begin
      // timer divisor per clock select code, 0 means no ticks
      int dv[8] = '{8, 16, 32, 64, 4, 0, 0, 1};
      int lo_t[8] = '{0, 1, 0, 4, 2, 9, 9, 4};
      int hi_t[8] = '{0, 1, 0, 6, 2, 11, 11, 11};
      logic [31:0] rv, a, v;
      int e, r0, duty;
      hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
      hsize = 3'h2; hwdata = 32'h0; sync_in = 5'h00; cpu_idle = 1'b0; fault_req = 3'h0;
      fail_count = 0; comparisons = 0; seed = 32'h0000232F;
      tick(20);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd(ocp_pkg::OFF_CTRL1, rv); check_val("ctrl one", {16'h0, ocp_pkg::CTRL1_RST}, rv);
      rd(ocp_pkg::OFF_CTRL2, rv); check_val("ctrl two", {16'h0, ocp_pkg::CTRL2_RST}, rv);
      rd(ocp_pkg::OFF_STATUS, rv); check_val("status", 32'h0, rv);
      check_val("response", 32'h0, hresp);
      check_val("oe at reset", 32'h0, pin_oe);
      wr(8'h1C, rnd()); rd(8'h1C, rv); check_val("unmapped", 32'h0, rv);
      v = rnd() & 32'h0000FFFF;
      wr(ocp_pkg::OFF_PRIM, v); rd(ocp_pkg::OFF_PRIM, rv); check_val("primary", v, rv);
      wr(ocp_pkg::OFF_CTRL2, 32'h00000100);
      rd(ocp_pkg::OFF_CTRL2, rv); check_val("cascade", 32'h00000100, rv);
      tick(1); check_val("oe driven", 32'h1, pin_oe);
      $display("test registers done");
      wr(ocp_pkg::OFF_PRIM, 32'h0000FFFF);
      for (int k = 0; k < 10; k++) begin
         e = (k < 8) ? k : 7;
         cpu_idle <= (k >= 8);
         wr(ocp_pkg::OFF_CTRL1, ((k == 8) << 13) | (e << 10) | 32'h1);
         tick(8); rd(ocp_pkg::OFF_COUNT, a);
         tick(W - 2); rd(ocp_pkg::OFF_COUNT, rv);
         e = (k == 8 || dv[e] == 0) ? 0 : W / dv[e];
         check_range("count delta", (e > 0) ? e - 1 : 0, e + 1, (rv - a) & 32'hFFFF);
      end
      cpu_idle <= 1'b0;
      $display("test clock select done");
      wr(ocp_pkg::OFF_CTRL2, 32'h0000001F);
      wr(ocp_pkg::OFF_SEC, 32'h00000013);
      wr(ocp_pkg::OFF_PRIM, 32'h00000005);
      for (int m = 0; m < 8; m++) begin
         wr(ocp_pkg::OFF_CTRL1, 32'h00001C00);
         wr(ocp_pkg::OFF_STATUS, 32'h00000003);
         r0 = rises;
         wr(ocp_pkg::OFF_CTRL1, 32'h00001C00 | m);
         tick(200);
         if (m == 4) begin
            wr(ocp_pkg::OFF_CTRL1, 32'h00001C04);
            tick(200);
         end
         check_range("pin rises", lo_t[m], hi_t[m], rises - r0);
         rd(ocp_pkg::OFF_STATUS, rv); check_val("match flag", m != 0, rv & 32'h1);
         if (m == 1 || m == 4) check_val("pin level", m == 1, pin_level);
      end
      $display("test modes done");
      for (int j = 0; j < 3; j++) begin
         duty = 1 + int'(rnd() % 32'd18);
         wr(ocp_pkg::OFF_PRIM, 32'(duty));
         wr(ocp_pkg::OFF_CTRL1, 32'h00001C06);
         tick(60); r0 = highs; tick(200);
         check_range("high cycles", 10 * duty - 1, 10 * duty + 1, highs - r0);
      end
      $display("test pwm done");
      for (int f = 0; f < 3; f++) begin
         wr(ocp_pkg::OFF_PRIM, 32'h00000005);
         wr(ocp_pkg::OFF_CTRL1, 32'h00001C06);
         fault_req <= 3'(1 << f);
         tick(20); r0 = rises; tick(100);
         check_range("rises fault off", 4, 6, rises - r0);
         wr(ocp_pkg::OFF_CTRL1, 32'h00001C06 | (1 << (7 + f)));
         tick(20); r0 = rises; tick(100);
         check_range("rises fault on", 0, 0, rises - r0);
         rd(ocp_pkg::OFF_CTRL1, rv); check_val("fault status", 1 << f, (rv >> 4) & 32'h7);
         rd(ocp_pkg::OFF_STATUS, rv); check_val("status fault", 32'h2, rv & 32'h2);
         check_val("irq masked", 32'h0, irq);
         wr(ocp_pkg::OFF_MASK, 32'h00000002); tick(1);
         check_val("irq raised", 32'h1, irq);
         fault_req <= 3'h0;
         tick(4);
         wr(ocp_pkg::OFF_CTRL1, 32'h00001C00);
         wr(ocp_pkg::OFF_STATUS, 32'h00000003); tick(1);
         check_val("irq cleared", 32'h0, irq);
         wr(ocp_pkg::OFF_MASK, 32'h00000000);
      end
      $display("test faults done");
      wr(ocp_pkg::OFF_CTRL2, 32'h00000082);
      rd(ocp_pkg::OFF_CTRL2, rv); check_val("trigger setup", 32'h00000082, rv);
      wr(ocp_pkg::OFF_PRIM, 32'h0000FFFF);
      wr(ocp_pkg::OFF_CTRL1, 32'h00001C09);
      tick(100);
      sync_in <= 5'h04; tick(4); sync_in <= 5'h00; tick(4);
      rd(ocp_pkg::OFF_COUNT, rv); check_range("count after sync", 0, 12, rv);
      wr(ocp_pkg::OFF_CTRL2, 32'h0000001F);
      for (int j = 0; j < 6; j++) begin
         tick(int'(rnd() % 32'd7));
         rd(ocp_pkg::OFF_COUNT, rv); check_range("count self sync", 0, 19, rv);
      end
      $display("test sync done");
      conclude();
   end
endmodule
